// ==== rtl/sync_serial_slave_rxtx.sv ====
// synchronous slave receive and transmit path with apb registers
// assumes an external master drives the shift clock pin; pins are synchronised to pclk
// Functional notes
// - in slave mode cont_rx counts as set, but the receiver idles while continuous enable is clear
// - single-word receive enable is ignored in slave mode
// - a complete shifted word moves into the receive holding buffer
// - receive interrupt enable lets a word arrival wake the core
// - slave mode means sync mode, port enabled, external clock source
// - nine-bit mode puts top bit in ninth bit, low eight in data
// - word completion sets receive flag; interrupt request if enabled
// - overrun clears by dropping continuous enable or port enable
// - reading receive data pops oldest character; flag clears when empty
// - during sleep only slave mode keeps shifting
// - both shift registers move only on external clock edges
// - while asleep the device accepts data and clock pins
// - full word during sleep sets receive flag, waking the core
// - device drives outgoing data on the data pin from the external clock
// - after shift-out, buffer moves to shift register and transmit flag sets
// - writing transmit buffer clears transmit flag; fills shifter then buffer (a write that goes into the free shifter leaves the flag set)
// - transmit wake needs transmit and peripheral interrupt enables
// - woken core with global enable calls the vector address
// - receive during sleep requires continuous enable set beforehand
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module sync_serial_slave_rxtx
  import sync_slave_pkg::*;
#(
  parameter int rx_fifo_depth = rx_depth
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        shift_clock_pin_i,
  input  wire logic        data_pin_i,
  output logic             data_pin_o,
  output logic             data_pin_oe,
  output logic             wake_q,
  output logic             irq_q,
  output logic             vector_call_q,
  output logic [11:0]      vector_q
);
  // control registers
  logic [7:0] baud_q, gic_q, pie_q, rsc_q, tsc_q;
  logic       sleep_q;
  logic       ovr_q;
  // pin synchronisers
  logic [1:0] ck_s_q, dt_s_q;
  logic       ck_prev_q;
  // shift state
  // nine bits wide so an optional ninth bit rides along
  logic [8:0] rsr_q;
  logic [3:0] rcnt_q;
  logic [8:0] tsr_q;
  logic [3:0] tcnt_q;
  logic       tsr_full_q;
  word9_t     txbuf_q;
  logic       txbuf_full_q;
  logic       txf_q;
  // receive buffer
  // one-bit pointers suffice for the two-entry buffer
  word9_t     rxmem_q [rx_fifo_depth];
  logic [1:0] rx_cnt_q;
  logic       rx_rd_q;
  logic       rx_wr_q;

  logic slave, cont_rx, tx_mode, rise, fall, nine_rx, nine_tx;
  logic wr, rd, word_done, rx_pop, tx_write, load_tsr;
  logic [3:0] rx_bits, tx_bits;

  // mode decode
  assign slave   = tsc_q[ts_sync_pos] & rsc_q[rs_port_en_pos] & ~tsc_q[ts_clk_src_pos];
  assign cont_rx = slave ? 1'b1 : rsc_q[rs_cont_pos];
  // receive selected by continuous enable only, single enable ignored
  assign tx_mode = slave & ~rsc_q[rs_cont_pos];
  // nine-bit selects only change the word length and the ninth-bit path
  assign nine_rx = rsc_q[rs_rx9_pos];
  assign nine_tx = tsc_q[ts_tx9_pos];
  assign rx_bits = nine_rx ? 4'h9 : 4'h8;
  assign tx_bits = nine_tx ? 4'h9 : 4'h8;

  // apb decode, zero wait states
  assign wr       = psel & penable & pwrite;
  assign rd       = psel & penable & ~pwrite;
  assign rx_pop   = rd & (paddr == receive_data_holding_off) & (rx_cnt_q != 2'h0);
  assign tx_write = wr & (paddr == transmit_buffer_off);

  // two-flop pin synchronisers and edge memory
  // the link clock is far slower than pclk, so edges are found after the synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ck_s_q    <= 2'b00;
      dt_s_q    <= 2'b00;
      ck_prev_q <= 1'b0;
    end
    else
    begin
      ck_s_q    <= {ck_s_q[0], shift_clock_pin_i};
      dt_s_q    <= {dt_s_q[0], data_pin_i};
      ck_prev_q <= ck_s_q[1];
    end
  end
  // shifting runs only in slave mode, asleep or not
  assign rise = slave & ck_s_q[1] & ~ck_prev_q;
  assign fall = slave & ~ck_s_q[1] & ck_prev_q;

  // receive shift register, lsb first, sampled on rising clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsr_q  <= 9'h000;
      rcnt_q <= cnt_reset;
    end
    else if (!rsc_q[rs_port_en_pos] || !cont_rx || tx_mode)
    begin
      // leaving slave receive drops a partial word, so no stale count remains
      rcnt_q <= cnt_reset;
    end
    else if (rise)
    begin
      rsr_q  <= {dt_s_q[1], rsr_q[8:1]};
      rcnt_q <= (rcnt_q == rx_bits - 4'h1) ? cnt_reset : rcnt_q + 4'h1;
    end
  end
  assign word_done = rise & cont_rx & ~tx_mode & (rcnt_q == rx_bits - 4'h1);

  // receive buffer, two entries, overrun when full
  // a word that meets a full buffer with no read in the same cycle is dropped and marks overrun
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_cnt_q <= 2'h0;
      rx_rd_q  <= 1'b0;
      rx_wr_q  <= 1'b0;
      ovr_q    <= 1'b0;
      for (int i = 0; i < rx_fifo_depth; i++)
        rxmem_q[i] <= '0;
    end
    else if (!rsc_q[rs_port_en_pos])
    begin
      // port disable flushes the whole receive side
      rx_cnt_q <= 2'h0;
      rx_rd_q  <= 1'b0;
      rx_wr_q  <= 1'b0;
      ovr_q    <= 1'b0;
    end
    else
    begin
      if (!rsc_q[rs_cont_pos])
        ovr_q <= 1'b0;
      // set after clear, so an overrun in the clearing cycle still sticks
      if (word_done && rx_cnt_q == 2'(rx_fifo_depth) && !rx_pop)
        ovr_q <= 1'b1;
      if (word_done && (rx_cnt_q != 2'(rx_fifo_depth) || rx_pop))
      begin
        // nine-bit word sits right-aligned in the shifter
        rxmem_q[rx_wr_q] <= nine_rx ? word9_t'({dt_s_q[1], rsr_q[8:1]}) : word9_t'({1'b0, dt_s_q[1], rsr_q[8:2]});
        rx_wr_q <= ~rx_wr_q;
      end
      if (rx_pop)
        rx_rd_q <= ~rx_rd_q;
      // count follows this cycle's push and pop together
      case ({word_done && (rx_cnt_q != 2'(rx_fifo_depth) || rx_pop), rx_pop})
        2'b10:   rx_cnt_q <= rx_cnt_q + 2'h1;
        2'b01:   rx_cnt_q <= rx_cnt_q - 2'h1;
        default: rx_cnt_q <= rx_cnt_q;
      endcase
    end
  end

  // transmit: write fills shifter first, then buffer
  // load_tsr marks the edge on which the buffer byte moves into the shifter
  assign load_tsr = tsr_full_q & fall & tx_mode & (tcnt_q == tx_bits - 4'h1) & txbuf_full_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tsr_q        <= 9'h000;
      tcnt_q       <= cnt_reset;
      tsr_full_q   <= 1'b0;
      txbuf_q      <= '0;
      txbuf_full_q <= 1'b0;
      txf_q        <= 1'b1;
    end
    else if (!rsc_q[rs_port_en_pos] || !tsc_q[ts_tx_en_pos])
    begin
      // disabling transmit or the port empties both stages and sets the flag
      tcnt_q       <= cnt_reset;
      tsr_full_q   <= 1'b0;
      txbuf_full_q <= 1'b0;
      txf_q        <= 1'b1;
    end
    else
    begin
      // one bit per synced falling edge; the last bit reloads or empties
      if (tsr_full_q && fall && tx_mode)
      begin
        tsr_q  <= {1'b0, tsr_q[8:1]};
        tcnt_q <= (tcnt_q == tx_bits - 4'h1) ? cnt_reset : tcnt_q + 4'h1;
        if (tcnt_q == tx_bits - 4'h1)
        begin
          if (txbuf_full_q)
          begin
            tsr_q        <= {txbuf_q.ninth, txbuf_q.data};
            txbuf_full_q <= 1'b0;
            txf_q        <= 1'b1;
          end
          else
            tsr_full_q <= 1'b0;
        end
      end
      if (tx_write)
      begin
        // a flag set in the same cycle beats the write's clear, though the new byte still fills the buffer
        // the shifter is free when empty or finishing its last bit with no buffer
        if (!tsr_full_q || (tx_mode && fall && tcnt_q == tx_bits - 4'h1 && !txbuf_full_q))
        begin
          tsr_q      <= {tsc_q[ts_ninth_pos], pwdata[7:0]};
          tsr_full_q <= 1'b1;
          tcnt_q     <= cnt_reset;
        end
        else
        begin
          txbuf_q      <= '{ninth: tsc_q[ts_ninth_pos], data: pwdata[7:0]};
          txbuf_full_q <= 1'b1;
          txf_q        <= load_tsr;
        end
      end
    end
  end

  // data pin drive while transmitting
  // the pin is released when the shifter is empty or the mode is receive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_pin_o  <= 1'b0;
      data_pin_oe <= 1'b0;
    end
    else
    begin
      data_pin_o  <= tsr_q[0];
      data_pin_oe <= tx_mode & tsc_q[ts_tx_en_pos] & tsr_full_q;
    end
  end

  // software registers
  // read-only status bits are stored as zero and filled in on read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_q  <= ctrl_reset;
      gic_q   <= ctrl_reset;
      pie_q   <= ctrl_reset;
      rsc_q   <= ctrl_reset;
      tsc_q   <= ctrl_reset;
      sleep_q <= 1'b0;
    end
    else
    begin
      if (wr && paddr == baud_rate_control_off)
        baud_q <= pwdata[7:0];
      if (wr && paddr == global_interrupt_control_off)
        gic_q <= pwdata[7:0];
      if (wr && paddr == peripheral_interrupt_enable_off)
        pie_q <= pwdata[7:0];
      if (wr && paddr == receive_status_control_off)
        rsc_q <= {pwdata[7:2], 2'b00};
      if (wr && paddr == transmit_status_control_off)
        tsc_q <= {pwdata[7:2], 1'b0, pwdata[0]};
      // sleep ends on wake
      // a sleep request in the wake cycle wins over the wake
      if (wr && paddr == power_control_off && pwdata[pc_sleep_pos])
        sleep_q <= 1'b1;
      else if (wake_q)
        sleep_q <= 1'b0;
    end
  end

  // interrupt request, wake and vector call
  // the wake pulse lasts one cycle and sleep drops on the following edge
  // the vector call rides on the wake pulse only with global enable set
  logic rx_req, tx_req;
  assign rx_req = (rx_cnt_q != 2'h0) & pie_q[pe_rx_pos];
  assign tx_req = txf_q & pie_q[pe_tx_pos] & gic_q[gi_periph_pos];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q         <= 1'b0;
      wake_q        <= 1'b0;
      vector_call_q <= 1'b0;
      vector_q      <= 12'h000;
    end
    else
    begin
      irq_q         <= rx_req | tx_req;
      wake_q        <= sleep_q & (rx_req | tx_req) & ~wake_q;
      vector_call_q <= sleep_q & (rx_req | tx_req) & ~wake_q & gic_q[gi_global_pos];
      vector_q      <= vector_addr;
    end
  end

  // apb read data and answer
  // read data is latched in setup, so the pop in access cannot disturb it
  // every access is answered one cycle after setup, no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      // unmapped or unaligned offsets answer with an error and read as zero
      pslverr <= psel & ~penable & (paddr > power_control_off || paddr[1:0] != 2'b00);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          baud_rate_control_off:           prdata <= {24'h000000, baud_q};
          global_interrupt_control_off:    prdata <= {24'h000000, gic_q};
          peripheral_interrupt_enable_off: prdata <= {24'h000000, pie_q};
          peripheral_interrupt_flags_off:  prdata <= {26'h0, rx_cnt_q != 2'h0, txf_q, 4'h0};
          receive_data_holding_off:        prdata <= {24'h000000, rxmem_q[rx_rd_q].data};
          receive_status_control_off:      prdata <= {24'h000000, rsc_q[7:2], ovr_q, rxmem_q[rx_rd_q].ninth};
          transmit_status_control_off:     prdata <= {24'h000000, tsc_q[7:2], ~tsr_full_q, tsc_q[0]};
          power_control_off:               prdata <= {30'h0, wake_q, sleep_q};
          default:                         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // sync_serial_slave_rxtx

// ==== include/sync_slave_pkg.sv ====
// constants, register map and carrier types for the synchronous slave serial path
// assumes a 32-bit apb register bus, one register per aligned word
package sync_slave_pkg;
  // register byte offsets
  localparam logic [7:0] baud_rate_control_off           = 8'h00;
  localparam logic [7:0] global_interrupt_control_off    = 8'h04;
  localparam logic [7:0] peripheral_interrupt_enable_off = 8'h08;
  localparam logic [7:0] peripheral_interrupt_flags_off  = 8'h0C;
  localparam logic [7:0] receive_data_holding_off        = 8'h10;
  localparam logic [7:0] receive_status_control_off      = 8'h14;
  localparam logic [7:0] transmit_status_control_off     = 8'h18;
  localparam logic [7:0] transmit_buffer_off             = 8'h1C;
  localparam logic [7:0] power_control_off               = 8'h20;
  // receive status / control bits
  localparam int rs_port_en_pos   = 7;
  localparam int rs_rx9_pos       = 6;
  localparam int rs_single_pos    = 5;
  localparam int rs_cont_pos      = 4;
  localparam int rs_ovr_pos       = 1;
  localparam int rs_ninth_pos     = 0;
  // transmit status / control bits
  localparam int ts_clk_src_pos   = 7;
  localparam int ts_tx9_pos       = 6;
  localparam int ts_tx_en_pos     = 5;
  localparam int ts_sync_pos      = 4;
  localparam int ts_empty_pos     = 1;
  localparam int ts_ninth_pos     = 0;
  // interrupt control, enable and flag bits
  localparam int gi_global_pos    = 7;
  localparam int gi_periph_pos    = 6;
  localparam int pe_rx_pos        = 5;
  localparam int pe_tx_pos        = 4;
  // power control bits
  localparam int pc_sleep_pos     = 0;
  localparam int pc_wake_pos      = 1;
  // reset values
  localparam logic [7:0] ctrl_reset   = 8'h00;
  localparam logic [7:0] tsc_reset    = 8'h02;
  localparam logic [3:0] cnt_reset    = 4'h0;
  localparam int         rx_depth     = 2;
  localparam logic [11:0] vector_addr = 12'h004;

  // one received word with its ninth bit
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } word9_t;
endpackage

// ==== verification/sync_serial_slave_rxtx_checker.sv ====
// port assertions for the slave serial block
// assumes one pclk domain, presetn async active low
`timescale 1ns/1ps
module sync_serial_slave_rxtx_checker
  import sync_slave_pkg::*;
#(
  parameter int rx_fifo_depth = rx_depth
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        shift_clock_pin_i,
  input wire logic        data_pin_i,
  input wire logic        data_pin_o,
  input wire logic        data_pin_oe,
  input wire logic        wake_q,
  input wire logic        irq_q,
  input wire logic        vector_call_q,
  input wire logic [11:0] vector_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answer timing and content
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_err; pready |-> pslverr == (paddr > 8'h20 || paddr[1:0] != 2'b00); endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_hi; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_ez; pready && pslverr |-> prdata == 32'h0; endproperty
  a_ez: assert property (p_ez) else $error("refused read not zero");
  // wake and vector behaviour
  property p_vec; vector_call_q |-> vector_q == 12'h004; endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_vw; vector_call_q |-> wake_q; endproperty
  a_vw: assert property (p_vw) else $error("vector call without wake");
  property p_wi; wake_q |-> irq_q; endproperty
  a_wi: assert property (p_wi) else $error("wake without interrupt request");
  property p_wk; $rose(wake_q) |=> !wake_q; endproperty
  a_wk: assert property (p_wk) else $error("wake not a pulse");
  c_wake: cover property (wake_q && vector_call_q);
  c_err: cover property (pready && pslverr);
  c_tx: cover property ($rose(data_pin_oe));
endmodule // sync_serial_slave_rxtx_checker

bind sync_serial_slave_rxtx sync_serial_slave_rxtx_checker #(.rx_fifo_depth(rx_fifo_depth)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .shift_clock_pin_i(shift_clock_pin_i),
  .data_pin_i(data_pin_i), .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe), .wake_q(wake_q), .irq_q(irq_q),
  .vector_call_q(vector_call_q), .vector_q(vector_q));

// ==== verification/sync_master_model.sv ====
// external synchronous master: makes the shift clock, drives or reads data
// assumes the bench resolves the shared data wire
`timescale 1ns/1ps
module sync_master_model (
  output logic     ck_o,
  output logic     dat_o,
  input wire logic dat_i
);
  // clock stands low between frames
  initial
  begin
    ck_o = 1'b0;
    dat_o = 1'b1;
  end
  // lsb first, one clock per bit, sample just before the rise
  task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h000;
    #7;
    for (int i = 0; i < n; i++)
    begin
      dat_o = tx[i];
      #160;
      rx[i] = dat_i;
      ck_o = 1'b1;
      #160;
      ck_o = 1'b0;
    end
    #160;
    dat_o = ~dat_o; // last bit inverted so the line shows no stale bit
  endtask
endmodule // sync_master_model

// ==== verification/sync_serial_slave_rxtx_tb_top.sv ====
// scenario bench: apb master, link master model, watchdog
// assumes the checker binds itself to the design
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module sync_serial_slave_rxtx_tb_top;
  import sync_slave_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        ck, m_dat, d_o, d_oe, wake, irq, vcall, vc_seen, e;
  logic [7:0]  paddr;
  logic [8:0]  rx;
  logic [11:0] vec;
  logic [31:0] pwdata, prdata, r;
  int          miscompares, num_checks, cyc, wakes;
  wire         dat_w;
  // device wins the data wire while it drives
  assign dat_w = d_oe ? d_o : m_dat;
  always #20 pclk = ~pclk;
  sync_serial_slave_rxtx dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .shift_clock_pin_i(ck),
    .data_pin_i(dat_w), .data_pin_o(d_o), .data_pin_oe(d_oe), .wake_q(wake), .irq_q(irq), .vector_call_q(vcall),
    .vector_q(vec));
  sync_master_model mdl_u (.ck_o(ck), .dat_o(m_dat), .dat_i(dat_w));
  // one apb transfer, held until ready
  task automatic xact(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xact(1'b0, a, 32'h0);
    `CHK(r, x)
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_regs;
    rd(transmit_status_control_off, {24'h0, tsc_reset});
    rd(peripheral_interrupt_flags_off, 32'h10);
    xact(1'b0, 8'h24, 32'h0);
    `CHK({e, r}, 33'h100000000)
  endtask
  task automatic t_rx;
    xact(1'b1, transmit_status_control_off, 32'h10);
    xact(1'b1, receive_status_control_off, 32'hB0);
    mdl_u.xfer(9'h0A5, 8, rx);
    repeat (6) @(posedge pclk);
    rd(peripheral_interrupt_flags_off, 32'h30);
    rd(receive_data_holding_off, 32'hA5);
    rd(peripheral_interrupt_flags_off, 32'h10);
    xact(1'b1, receive_status_control_off, 32'hD0);
    mdl_u.xfer(9'h13C, 9, rx);
    repeat (6) @(posedge pclk);
    rd(receive_status_control_off, 32'hD1);
    rd(receive_data_holding_off, 32'h3C);
  endtask
  task automatic t_ovr;
    xact(1'b1, receive_status_control_off, 32'h90);
    for (int i = 1; i < 4; i++)
      mdl_u.xfer(9'(i * 17), 8, rx);
    repeat (6) @(posedge pclk);
    rd(receive_status_control_off, 32'h92);
    rd(receive_data_holding_off, 32'h11);
    rd(receive_data_holding_off, 32'h22);
    xact(1'b1, receive_status_control_off, 32'h80);
    xact(1'b0, receive_status_control_off, 32'h0);
    `CHK(r[7:1], 7'h40)
  endtask
  task automatic t_slp;
    int w0;
    xact(1'b1, receive_status_control_off, 32'h90);
    xact(1'b1, peripheral_interrupt_enable_off, 32'h20);
    xact(1'b1, global_interrupt_control_off, 32'h80);
    xact(1'b1, power_control_off, 32'h01);
    w0 = wakes;
    mdl_u.xfer(9'h05C, 8, rx);
    repeat (6) @(posedge pclk);
    `CHK(wakes, w0 + 1)
    `CHK(vc_seen, 1'b1)
    `CHK(irq, 1'b1)
    `CHK(vec, 12'h004)
    rd(receive_data_holding_off, 32'h5C);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_tx;
    int w0;
    xact(1'b1, receive_status_control_off, 32'h80);
    xact(1'b1, peripheral_interrupt_enable_off, 32'h10);
    xact(1'b1, global_interrupt_control_off, 32'h40);
    xact(1'b1, transmit_status_control_off, 32'h30);
    xact(1'b1, transmit_buffer_off, 32'h5A);
    xact(1'b1, transmit_buffer_off, 32'hC3);
    rd(peripheral_interrupt_flags_off, 32'h00);
    `CHK(d_oe, 1'b1)
    `CHK(irq, 1'b0)
    xact(1'b1, power_control_off, 32'h01);
    w0 = wakes;
    mdl_u.xfer(9'h000, 8, rx);
    `CHK(rx[7:0], 8'h5A)
    repeat (6) @(posedge pclk);
    `CHK(wakes, w0 + 1)
    `CHK(vc_seen, 1'b0)
    rd(peripheral_interrupt_flags_off, 32'h10);
    mdl_u.xfer(9'h000, 8, rx);
    `CHK(rx[7:0], 8'hC3)
    xact(1'b1, transmit_status_control_off, 32'h71);
    xact(1'b1, transmit_buffer_off, 32'h96);
    mdl_u.xfer(9'h000, 9, rx);
    `CHK(rx, 9'h196)
    repeat (2) @(posedge pclk);
    `CHK(d_oe, 1'b0)
  endtask
  // watchdog and wake pulse monitor
  always @(posedge pclk)
  begin
    cyc++;
    if (wake === 1'b1)
    begin
      wakes++;
      vc_seen = vcall;
    end
    if (cyc == 20000)
    begin
      miscompares++;
      wrap_up;
    end
  end
  // reset, then scenarios in order
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_rx;
    t_ovr;
    t_slp;
    t_tx;
    wrap_up;
  end
endmodule // sync_serial_slave_rxtx_tb_top
